/* rtl/clk_mode_cfg.svh */
`ifndef CLK_MODE_CFG_SVH
`define CLK_MODE_CFG_SVH
// Operation
// - Instruction tick is selected oscillator tick divided by four.
// - High oscillator stop bit halts high oscillator, low keeps running.
// - Clock mode bit picks high clock (0) or low clock (1).
// - Mode field: 00 normal, 01 sleep, 10 green, 11 reserved.
// - Watchdog rate bit: 0 prescales by 2^14, 1 by 2^8.
// - Writing 1 to watchdog clear restarts the watchdog; 0 does nothing.
// - Watchdog source bit: 0 instruction tick, 1 low RC tick.
// - Watchdog overflows after 16 prescaled counts; RC source prescales 512.
// - Sleep stops both oscillators and halts execution.
// - Low oscillator stops only in sleep; no separate control.
// - Sleep exits only on pin wake or reset, always to normal.
// - Sleep wake waits oscillator start plus 2048 high clock cycles.
// - Green wakes on pin, reset or enabled timer; resumes prior mode.
// - Port 0 always wakes; port 1 pins wake only when enabled.
// - Watchdog overflow causes system reset and return to normal.

// ===========================================================
// Register indices and byte addresses (byte address = 4 x index)
`define IDX_P1_WAKE 8'hc0
`define IDX_OSC_MODE 8'hca
`define ADR_P1_WAKE 12'h300
`define ADR_OSC_MODE 12'h328
`define RST_P1_WAKE 8'h00
`define RST_OSC_MODE 8'h00

// ===========================================================
// Field positions of the oscillator mode register
`define BIT_HOSC_STOP 1
`define BIT_SLOW_SEL 2
`define BIT_MODE_LO 3
`define BIT_MODE_HI 4
`define BIT_WD_RATE 5
`define BIT_WD_CLR 6
`define BIT_WD_SRC 7

// ===========================================================
// Mode encodings and counts
`define MODE_NORMAL 2'h0
`define MODE_SLEEP 2'h1
`define MODE_GREEN 2'h2
`define CPU_DIV_LAST 2'h3
`define WD_PRE_SLOW 14'h3fff
`define WD_PRE_FAST 14'h00ff
`define WD_PRE_LRC 14'h01ff
`define WD_OVF_LAST 4'hf
`define WARMUP_LAST 11'h7ff
`endif

/* rtl/clk_mode_pkg.sv */
package clk_mode_pkg;

  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_GREEN = 4'b0010,
    ST_SLEEP = 4'b0100,
    ST_WARM = 4'b1000
  } pm_state_t;

  typedef struct packed {
    logic wd_src;
    logic wd_clr;
    logic wd_rate;
    logic [1:0] cpu_mode;
    logic slow_sel;
    logic hosc_stop;
    logic zero;
  } osc_mode_t;

  typedef struct packed {
    logic [7:0] port0;
    logic [7:0] port1;
  } wake_pins_t;

  typedef struct packed {
    logic hosc_tick;
    logic hosc_ready;
    logic losc_tick;
    logic lrc_tick;
  } osc_ticks_t;

endpackage : clk_mode_pkg

/* rtl/clock_and_power_mode_control.sv */
`include "clk_mode_cfg.svh"

module clock_and_power_mode_control
  import clk_mode_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Oscillator ticks and status
  input wire osc_ticks_t osc,
  // Wakeup pins, low level wakes
  input wire wake_pins_t pins,
  // Basic timer
  input wire logic basic_timer_enable,
  input wire logic basic_timer_wake,
  // Watchdog code option
  input wire logic wdog_enable,
  // Clock and mode outputs
  output logic high_osc_enable,
  output logic low_osc_enable,
  output logic cpu_tick,
  output logic cpu_running,
  output pm_state_t power_state,
  output logic system_reset_req
);

  // ===========================================================
  // Watchdog prescale terminal count

  function automatic logic [13:0] wd_pre_last(
    input logic src,
    input logic rate
  );
    if (src)
      wd_pre_last = `WD_PRE_LRC;
    else if (rate)
      wd_pre_last = `WD_PRE_FAST;
    else
      wd_pre_last = `WD_PRE_SLOW;
  endfunction : wd_pre_last

  // ===========================================================
  // State

  osc_mode_t mode_reg;
  logic [7:0] p1_wake;
  pm_state_t state;
  logic [1:0] cpu_div;
  logic [10:0] warm_cnt;
  logic [13:0] wd_pre;
  logic [3:0] wd_cnt;

  osc_mode_t next_mode;
  pm_state_t next_state;

  // ===========================================================
  // Bus decode

  wire logic req;
  wire logic hit_osc;
  wire logic hit_p1;
  wire logic wr_ok;
  wire logic wr_osc;
  wire logic wr_p1;
  wire osc_mode_t wdat;
  wire logic [31:0] rd_mux;

  assign req = wb_cyc_i & wb_stb_i;
  assign hit_osc = wb_adr_i == `ADR_OSC_MODE;
  assign hit_p1 = wb_adr_i == `ADR_P1_WAKE;
  // Write lands on the edge where the master sees ack
  assign wr_ok = req & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign wr_osc = wr_ok & hit_osc;
  assign wr_p1 = wr_ok & hit_p1;
  assign wdat = osc_mode_t'(wb_dat_i[7:0]);
  // Port 1 wake register is write only and reads zero
  assign rd_mux = hit_osc ? {24'h000000, mode_reg} : 32'h00000000;

  // ===========================================================
  // State and mode decode

  wire logic in_green;
  wire logic in_sleep;
  wire logic in_warm;
  wire logic want_sleep;
  wire logic want_green;

  assign in_green = state == ST_GREEN;
  assign in_sleep = state == ST_SLEEP;
  assign in_warm = state == ST_WARM;
  // Code 11 is reserved and matches neither, so the block stays put
  assign want_sleep = mode_reg.cpu_mode == `MODE_SLEEP;
  assign want_green = mode_reg.cpu_mode == `MODE_GREEN;

  // ===========================================================
  // Wakeup sources

  wire logic pin_wake;
  wire logic timer_wake;
  wire logic green_wake;

  assign pin_wake = (|(~pins.port0)) | (|(~pins.port1 & p1_wake));
  assign timer_wake = basic_timer_enable & basic_timer_wake;
  assign green_wake = pin_wake | timer_wake;

  // ===========================================================
  // Clock selection and division

  wire logic hosc_live;
  wire logic losc_live;
  wire logic sel_tick;
  wire logic in_run;
  wire logic next_cpu_tick;

  assign hosc_live = osc.hosc_tick & high_osc_enable;
  assign losc_live = osc.losc_tick & low_osc_enable;
  assign sel_tick = mode_reg.slow_sel ? losc_live : hosc_live;
  assign in_run = state == ST_RUN;
  // Execution halts outside run, so no ticks there
  assign next_cpu_tick = in_run & sel_tick & (cpu_div == `CPU_DIV_LAST);

  // ===========================================================
  // Watchdog

  wire logic wd_clear;
  wire logic wd_tick;
  wire logic wd_pre_wrap;
  wire logic wd_ovf;

  assign wd_clear = wr_osc & wdat.wd_clr;
  assign wd_tick = wdog_enable &
                   (mode_reg.wd_src ? osc.lrc_tick : cpu_tick);
  assign wd_pre_wrap = wd_tick &
    (wd_pre == wd_pre_last(mode_reg.wd_src, mode_reg.wd_rate));
  assign wd_ovf = wd_pre_wrap & (wd_cnt == `WD_OVF_LAST) & ~wd_clear;

  // ===========================================================
  // Sleep warm-up

  wire logic warm_tick;
  wire logic warm_done;

  // Counting waits for the oscillator to report a stable start
  assign warm_tick = osc.hosc_ready & osc.hosc_tick;
  assign warm_done = warm_tick & (warm_cnt == `WARMUP_LAST);

  // ===========================================================
  // Mode sequencing

  wire logic leave_green;
  wire logic leave_sleep;
  wire logic leave;

  assign leave_green = in_green & green_wake;
  // Only pins end sleep; the timer has no say there
  assign leave_sleep = in_sleep & pin_wake;
  assign leave = leave_green | leave_sleep;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_RUN:
      begin
        if (want_sleep)
          next_state = ST_SLEEP;
        else if (want_green)
          next_state = ST_GREEN;
      end
      ST_GREEN:
      begin
        // Clock select is untouched, so the prior mode resumes
        if (green_wake)
          next_state = ST_RUN;
      end
      ST_SLEEP:
      begin
        // Timer is ignored here: only pins or reset end sleep
        if (pin_wake)
          next_state = ST_WARM;
      end
      ST_WARM:
      begin
        if (warm_done)
          next_state = ST_RUN;
      end
      default:
        next_state = ST_RUN;
    endcase
    if (wd_ovf)
      next_state = ST_RUN;
  end

  always_comb
  begin
    next_mode = mode_reg;
    if (wr_osc)
    begin
      next_mode = wdat;
      next_mode.wd_clr = 1'b0;
      next_mode.zero = 1'b0;
    end
    // Hardware clear wins; software is halted while asleep
    if (leave)
      next_mode.cpu_mode = `MODE_NORMAL;
    // Sleep exit lands in normal mode on a running high clock, even
    // when the block went to sleep from slow mode
    if (leave_sleep)
    begin
      next_mode.slow_sel = 1'b0;
      next_mode.hosc_stop = 1'b0;
    end
    if (wd_ovf)
      next_mode = osc_mode_t'(`RST_OSC_MODE);
  end

  // ===========================================================
  // Oscillator enables follow the next state

  wire logic next_hosc_en;
  wire logic next_losc_en;

  assign next_hosc_en = (next_state == ST_SLEEP) ? 1'b0 :
                        (next_state == ST_WARM) ? 1'b1 :
                        ~next_mode.hosc_stop;
  assign next_losc_en = next_state != ST_SLEEP;

  // ===========================================================
  // Next values of the bus and wake registers

  wire logic take;
  wire logic [31:0] next_dat;
  wire logic [7:0] next_p1_wake;

  // A request is taken once; ack falls the cycle after even if held
  assign take = req & ~wb_ack_o;
  assign next_dat = take ? rd_mux : 32'h00000000;
  // Watchdog overflow restores the enables like any other reset
  assign next_p1_wake = wd_ovf ? `RST_P1_WAKE :
                        wr_p1 ? wb_dat_i[7:0] : p1_wake;

  // ===========================================================
  // Registers

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= take;
      wb_dat_o <= next_dat;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      mode_reg <= osc_mode_t'(`RST_OSC_MODE);
      p1_wake <= `RST_P1_WAKE;
      state <= ST_RUN;
    end
    else
    begin
      mode_reg <= next_mode;
      p1_wake <= next_p1_wake;
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      cpu_div <= 2'h0;
    else if (!in_run)
      cpu_div <= 2'h0;
    else if (sel_tick)
      cpu_div <= cpu_div + 2'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      warm_cnt <= 11'h000;
    else if (!in_warm)
      warm_cnt <= 11'h000;
    else if (warm_tick)
      warm_cnt <= warm_cnt + 11'h001;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wd_pre <= 14'h0000;
      wd_cnt <= 4'h0;
    end
    else if (wd_clear | wd_ovf | ~wdog_enable)
    begin
      wd_pre <= 14'h0000;
      wd_cnt <= 4'h0;
    end
    else if (wd_pre_wrap)
    begin
      wd_pre <= 14'h0000;
      wd_cnt <= wd_cnt + 4'h1;
    end
    else if (wd_tick)
      wd_pre <= wd_pre + 14'h0001;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      high_osc_enable <= 1'b1;
      low_osc_enable <= 1'b1;
      cpu_tick <= 1'b0;
      cpu_running <= 1'b1;
      power_state <= ST_RUN;
      system_reset_req <= 1'b0;
    end
    else
    begin
      high_osc_enable <= next_hosc_en;
      low_osc_enable <= next_losc_en;
      cpu_tick <= next_cpu_tick;
      cpu_running <= next_state == ST_RUN;
      power_state <= next_state;
      system_reset_req <= wd_ovf;
    end
  end

endmodule : clock_and_power_mode_control

/* test/osc_wake_model.sv */
module osc_wake_model
  import clk_mode_pkg::*;
(
  // Clock, enables from the block and pin presses
  input wire logic sys_clk,
  input wire logic high_osc_enable,
  input wire logic low_osc_enable,
  input wire logic [15:0] press,
  // Far side
  output osc_ticks_t osc,
  output wake_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // =====
  // Oscillators: ready lags enable by 15 cycles of start-up
  logic [3:0] start = 4'h0;
  logic lo_ph = 1'b0;
  always @(posedge sys_clk)
  begin
    start <= high_osc_enable ? start + {3'h0, ~&start} : 4'h0;
    lo_ph <= low_osc_enable & ~lo_ph;
  end
  assign osc = {high_osc_enable, &start, lo_ph, 1'b1};
  // Pull-ups hold released pins high
  assign pins = ~press;
endmodule : osc_wake_model

/* test/clock_and_power_mode_control_chk.sv */
module clock_and_power_mode_control_chk
  import clk_mode_pkg::*;
(
  // Watched ports
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire osc_ticks_t osc,
  input wire wake_pins_t pins,
  input wire logic basic_timer_enable,
  input wire logic basic_timer_wake,
  input wire logic high_osc_enable,
  input wire logic low_osc_enable,
  input wire logic cpu_tick,
  input wire pm_state_t power_state,
  input wire logic system_reset_req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] warm;
  logic slp;
  assign slp = power_state == ST_SLEEP;
  // =====
  // Ready ticks seen during warm-up
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || power_state != ST_WARM)
      warm <= 12'h000;
    else
      warm <= warm + {11'h000, osc.hosc_tick & osc.hosc_ready};
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_div; cpu_tick |=> !cpu_tick [*3]; endproperty
  a_div: assert property (p_div) else $error("tick gap");
  property p_slp; slp |-> !high_osc_enable && !low_osc_enable; endproperty
  a_slp: assert property (p_slp) else $error("osc on");
  property p_low; !low_osc_enable |-> slp; endproperty
  a_low: assert property (p_low) else $error("low osc off");
  property p_hold; slp && (&pins) |=> slp; endproperty
  a_hold: assert property (p_hold) else $error("left sleep");
  property p_pin; slp && !(&pins.port0) |=> power_state == ST_WARM;
  endproperty
  a_pin: assert property (p_pin) else $error("no wake");
  property p_warm; power_state == ST_WARM ##1 power_state == ST_RUN
    |-> warm inside {[12'd2045:12'd2050]}; endproperty
  a_warm: assert property (p_warm) else $error("warm-up");
  property p_grn; power_state == ST_GREEN && basic_timer_enable
    && basic_timer_wake |=> power_state == ST_RUN; endproperty
  a_grn: assert property (p_grn) else $error("no timer wake");
  property p_wdr; system_reset_req
    |=> !system_reset_req && power_state == ST_RUN; endproperty
  a_wdr: assert property (p_wdr) else $error("reset pulse");
endmodule : clock_and_power_mode_control_chk

bind clock_and_power_mode_control clock_and_power_mode_control_chk chk (.*);

/* test/tb.sv */
module tb
  import clk_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [15:0] press = 16'h0000;
  logic basic_timer_enable = 1'b0;
  logic basic_timer_wake = 1'b0;
  logic wdog_enable = 1'b0;
  logic [31:0] wb_dat_o, rv;
  logic wb_ack_o, high_osc_enable, low_osc_enable, cpu_tick, cpu_running;
  logic system_reset_req;
  osc_ticks_t osc;
  wake_pins_t pins;
  pm_state_t power_state;
  int fail_count = 0;
  int compares = 0;
  int n;
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
  clock_and_power_mode_control dut (.*);
  osc_wake_model far (.*);
  always #50 sys_clk = ~sys_clk;
  // =====
  // Bus and wait helpers
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    // No cycle count is assumed; only the run watchdog ends a hang
    do
      @(posedge sys_clk);
    while (wb_ack_o !== 1'b1);
    rv = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask : wb
  task automatic go(input pm_state_t s);
    n = 0;
    while (power_state !== s && n < 3000)
      @(posedge sys_clk) n++;
    `CHK(power_state, s)
  endtask : go
  // =====
  // Scenarios
  task automatic t_clock;
    wb(1'b1, 12'h300, 8'h5a);
    wb(1'b0, 12'h300, 8'h00);
    `CHK(rv, 32'h0)
    wb(1'b0, 12'h004, 8'h00);
    `CHK(rv, 32'h0)
    wb(1'b1, 12'h328, 8'h06);
    repeat (8) @(posedge sys_clk);
    `CHK({high_osc_enable, low_osc_enable}, 2'b01)
    n = 0;
    repeat (40) @(posedge sys_clk) n += int'(cpu_tick === 1'b1);
    `CHK(n, 5)
    wb(1'b1, 12'h328, 8'h04);
    repeat (30) @(posedge sys_clk);
    wb(1'b1, 12'h328, 8'h00);
    n = 0;
    repeat (40) @(posedge sys_clk) n += int'(cpu_tick === 1'b1);
    `CHK(n, 10)
    $display("clock end");
  endtask : t_clock
  task automatic t_sleep;
    wb(1'b1, 12'h300, 8'h02);
    wb(1'b1, 12'h328, 8'h0e);
    go(ST_SLEEP);
    `CHK({cpu_running, high_osc_enable, low_osc_enable}, 3'b000)
    basic_timer_enable <= 1'b1;
    basic_timer_wake <= 1'b1;
    press <= 16'h0001;
    repeat (10) @(posedge sys_clk);
    `CHK(power_state, ST_SLEEP)
    press <= 16'h0800;
    go(ST_WARM);
    press <= 16'h0000;
    basic_timer_enable <= 1'b0;
    go(ST_RUN);
    `CHK(n > 2047, 1'b1)
    wb(1'b0, 12'h328, 8'h00);
    `CHK(rv, 32'h0)
    $display("sleep end");
  endtask : t_sleep
  task automatic t_green;
    wb(1'b1, 12'h328, 8'h14);
    go(ST_GREEN);
    repeat (10) @(posedge sys_clk);
    `CHK({cpu_running, power_state}, {1'b0, ST_GREEN})
    press <= 16'h0002;
    go(ST_RUN);
    press <= 16'h0000;
    wb(1'b0, 12'h328, 8'h00);
    `CHK(rv, 32'h4)
    basic_timer_wake <= 1'b0;
    basic_timer_enable <= 1'b1;
    wb(1'b1, 12'h328, 8'h14);
    go(ST_GREEN);
    repeat (5) @(posedge sys_clk);
    `CHK(power_state, ST_GREEN)
    basic_timer_wake <= 1'b1;
    go(ST_RUN);
    `CHK(power_state, ST_RUN)
    basic_timer_enable <= 1'b0;
    basic_timer_wake <= 1'b0;
    wb(1'b1, 12'h328, 8'h00);
    $display("green end");
  endtask : t_green
  task automatic t_wdog;
    wdog_enable <= 1'b1;
    wb(1'b1, 12'h328, 8'h80);
    repeat (6000) @(posedge sys_clk);
    wb(1'b1, 12'h328, 8'hc0);
    repeat (6000) @(posedge sys_clk);
    wb(1'b0, 12'h328, 8'h00);
    `CHK(rv, 32'h80)
    wb(1'b1, 12'h328, 8'hc0);
    n = 0;
    while (system_reset_req !== 1'b1 && n < 9000)
      @(posedge sys_clk) n++;
    `CHK(n inside {[8180:8200]}, 1'b1)
    @(posedge sys_clk);
    wb(1'b0, 12'h328, 8'h00);
    `CHK({rv, power_state}, {32'h0, ST_RUN})
    // Fast rate on the instruction tick: 2^8 x 16 ticks of 4 cycles
    wb(1'b1, 12'h328, 8'h60);
    n = 0;
    while (system_reset_req !== 1'b1 && n < 20000)
      @(posedge sys_clk) n++;
    `CHK(n inside {[16376:16392]}, 1'b1)
    wdog_enable <= 1'b0;
    $display("watchdog end");
  endtask : t_wdog
  task automatic finish_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  initial
  begin
    #6000000;
    fail_count++;
    finish_test();
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_clock();
    t_sleep();
    t_green();
    t_wdog();
    finish_test();
  end
endmodule : tb
